//--- rtl/cotpm_config.sv
// Purpose: Object dictionary bank for TPDO mapping, start-up state and node settings
// Assumes: One dictionary access per request pulse, answered on the next edge
// Notes: Variant strap is caught in the cycle after reset release
// What this block does
// - Two mapping objects, entries pack index/sub/length
// - One-axis default: count one, X-axis entry
// - Two-axis default: X then Y entries
// - Second PDO mapping count zero after reset
// - Remap in pre-op/operational, PDO disabled, count zero
// - Writing a predefined function mode reloads the default mapping
// - Start-up object zero: operational; four: pre-op
// - Operational: send first PDO, heartbeat 05
// - Node ID 1..127, default one
// - Bit rate codes 0..8 decoded, default 250
// - Termination: zero off, one on, default off
// - Profiles 0..3 valid, 4..6 reserved, default one
// - Function modes 0..5 and FF, default zero
// - Moving average: top subindex, two lengths
// - Filter tau sets cutoff, above event time
// - Zero adjust 1/2/3 starts X/Y/both
// - Error mask gates status into error event
// - Status bytes 0-7, 8-15, 16-23 readable
// - Fourth status byte carries bits 24-31
`timescale 1ns/1ps
module cotpm_config #(
  parameter int MAP_ENTRIES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Dictionary access
  input wire logic odReq,
  input wire cotpm_pkg::cotpm_req_type odReqIn,
  output logic odAck,
  output logic odErr,
  output logic [31:0] odRdata,
  // Device context
  input wire logic twoAxis,
  input wire logic selfTestPass,
  input wire logic nmtStartCmd,
  input wire logic nmtPreopCmd,
  input wire logic nmtResetCmd,
  input wire logic [1:0] tpdoDisabled,
  input wire logic measTick,
  input wire logic [31:0] mfgStatus,
  // Results
  output cotpm_pkg::cotpm_nmt_type nmtState,
  output logic [7:0] heartbeatState,
  output logic tpdo1Send,
  output logic mfgError,
  output cotpm_pkg::cotpm_cfg_type cfg
);
  import cotpm_pkg::*;

  localparam int EW = (MAP_ENTRIES > 1) ? $clog2(MAP_ENTRIES) : 1;
  localparam logic [7:0] MAP_TOP = 8'(MAP_ENTRIES);

  function automatic logic inRange(input logic [31:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
    inRange = (v[31:8] == 24'h000000) && (v[7:0] >= lo) && (v[7:0] <= hi);
  endfunction : inRange

  function automatic logic [15:0] rateKbps(input logic [7:0] code);
    unique case (code)
      8'h00: rateKbps = 16'h03E8;
      8'h01: rateKbps = 16'h0320;
      8'h02: rateKbps = 16'h01F4;
      8'h03: rateKbps = 16'h00FA;
      8'h04: rateKbps = 16'h007D;
      8'h05: rateKbps = 16'h0064;
      8'h06: rateKbps = 16'h0032;
      8'h07: rateKbps = 16'h0014;
      8'h08: rateKbps = 16'h000A;
      default: rateKbps = 16'h0000;
    endcase
  endfunction : rateKbps

  logic [7:0] mapCount_r [2];
  logic [31:0] mapEntry_r [2][MAP_ENTRIES];
  logic loadDefault_r;
  logic [31:0] startup_r, errMask_r, odRdata_r;
  logic [7:0] nodeId_r, bitRate_r, term_r, profile_r, mode_r;
  logic [7:0] mavg1_r, mavg2_r, zeroAdj_r;
  logic [15:0] tau_r, kbps_r;
  logic zeroX_r, zeroY_r, mfgErr_r, tpdo1Send_r, odAck_r, odErr_r;
  cotpm_nmt_type nmt_r;
  logic [7:0] hb_r;
  // Access decode
  logic pdoSel, remapOpen, accErr, wrEn;
  logic [EW-1:0] entIdx;
  logic [7:0] entSub;
  logic [31:0] rdVal;
  assign pdoSel = (odReqIn.index == IDX_TPDO2_MAP);
  assign entSub = odReqIn.sub - 8'h01;
  assign entIdx = entSub[EW-1:0];
  assign remapOpen = (nmt_r != NMT_BOOT) && tpdoDisabled[pdoSel];

  always_comb begin
    rdVal = '0;
    accErr = 1'b1;
    case (odReqIn.index)
      IDX_TPDO1_MAP, IDX_TPDO2_MAP: begin
        if (odReqIn.sub == 8'h00) begin
          rdVal = {24'h000000, mapCount_r[pdoSel]};
          if (!odReqIn.write) begin
            accErr = 1'b0;
          end else if (remapOpen && inRange(odReqIn.wdata, 8'h00, MAP_TOP) &&
                       (mapCount_r[pdoSel] == 8'h00 || odReqIn.wdata == '0)) begin
            accErr = 1'b0;
          end
        end else if (odReqIn.sub <= MAP_TOP) begin
          rdVal = mapEntry_r[pdoSel][entIdx];
          if (!odReqIn.write) begin
            accErr = 1'b0;
          end else if (remapOpen && mapCount_r[pdoSel] == 8'h00) begin
            accErr = 1'b0;
          end
        end
      end
      IDX_STARTUP: begin
        rdVal = startup_r;
        accErr = odReqIn.write && odReqIn.wdata != STARTUP_OPER &&
                 odReqIn.wdata != STARTUP_PREOP;
      end
      IDX_NODE_ID: begin
        rdVal = {24'h000000, nodeId_r};
        accErr = odReqIn.write && !inRange(odReqIn.wdata, 8'h01, NODE_ID_MAX);
      end
      IDX_BIT_RATE: begin
        rdVal = {24'h000000, bitRate_r};
        accErr = odReqIn.write && !inRange(odReqIn.wdata, 8'h00, BIT_RATE_MAX);
      end
      IDX_TERMINATION: begin
        rdVal = {24'h000000, term_r};
        accErr = odReqIn.write && !inRange(odReqIn.wdata, 8'h00, TERM_MAX);
      end
      IDX_PROFILE: begin
        rdVal = {24'h000000, profile_r};
        accErr = odReqIn.write && !inRange(odReqIn.wdata, 8'h00, PROFILE_MAX);
      end
      IDX_FUNC_MODE: begin
        rdVal = {24'h000000, mode_r};
        accErr = odReqIn.write && !inRange(odReqIn.wdata, 8'h00, MODE_MAX) &&
                 odReqIn.wdata != {24'h000000, MODE_USER};
      end
      IDX_MOVING_AVG: begin
        unique case (odReqIn.sub)
          8'h00: begin
            rdVal = {24'h000000, MAVG_TOP_SUB};
            accErr = odReqIn.write;
          end
          8'h01: begin
            rdVal = {24'h000000, mavg1_r};
            accErr = odReqIn.write && odReqIn.wdata[31:8] != 24'h000000;
          end
          8'h02: begin
            rdVal = {24'h000000, mavg2_r};
            accErr = odReqIn.write && odReqIn.wdata[31:8] != 24'h000000;
          end
          default: accErr = 1'b1;
        endcase
      end
      IDX_FILTER_TAU: begin
        rdVal = {16'h0000, tau_r};
        accErr = odReqIn.write && odReqIn.wdata[31:16] != 16'h0000;
      end
      IDX_ZERO_ADJUST: begin
        rdVal = {24'h000000, zeroAdj_r};
        accErr = odReqIn.write && !inRange(odReqIn.wdata, 8'h00, ZERO_ADJ_MAX);
      end
      IDX_ERROR_MASK: begin
        rdVal = errMask_r;
        accErr = 1'b0;
      end
      IDX_STATUS_MAP: begin
        accErr = odReqIn.write || odReqIn.sub > STATUS_TOP_SUB;
        unique case (odReqIn.sub)
          8'h00: rdVal = {24'h000000, STATUS_TOP_SUB};
          8'h01: rdVal = {24'h000000, mfgStatus[7:0]};
          8'h02: rdVal = {24'h000000, mfgStatus[15:8]};
          8'h03: rdVal = {24'h000000, mfgStatus[23:16]};
          8'h04: rdVal = {24'h000000, mfgStatus[31:24]};
          default: rdVal = '0;
        endcase
      end
      default: accErr = 1'b1;
    endcase
  end

  assign wrEn = odReq && odReqIn.write && !accErr;
  function automatic logic hit(input logic [15:0] idx, input logic [15:0] want);
    hit = (idx == want);
  endfunction : hit
  // Access answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      odAck_r <= 1'b0;
      odErr_r <= 1'b0;
      odRdata_r <= '0;
    end else begin
      odAck_r <= odReq;
      odErr_r <= odReq && accErr;
      odRdata_r <= (odReq && !odReqIn.write && !accErr) ? rdVal : '0;
    end
  end

  // Mapping objects
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < 2; p++) begin
        mapCount_r[p] <= MAP_COUNT_TPDO2;
        for (int e = 0; e < MAP_ENTRIES; e++) begin
          mapEntry_r[p][e] <= '0;
        end
      end
    end else if (loadDefault_r) begin
      mapCount_r[0] <= twoAxis ? MAP_COUNT_TWO_AXIS : MAP_COUNT_ONE_AXIS;
      mapEntry_r[0][0] <= MAP_X_AXIS;
      for (int e = 1; e < MAP_ENTRIES; e++) begin
        mapEntry_r[0][e] <= (e == 1 && twoAxis) ? MAP_Y_AXIS : '0;
      end
    end else if (wrEn && (hit(odReqIn.index, IDX_TPDO1_MAP) ||
                          hit(odReqIn.index, IDX_TPDO2_MAP))) begin
      if (odReqIn.sub == 8'h00) begin
        mapCount_r[pdoSel] <= odReqIn.wdata[7:0];
      end else begin
        mapEntry_r[pdoSel][entIdx] <= odReqIn.wdata;
      end
    end
  end

  // Default reload after reset and on a new predefined function mode
  always_ff @(posedge clk) begin
    if (rst) begin
      loadDefault_r <= 1'b1;
    end else begin
      loadDefault_r <= wrEn && hit(odReqIn.index, IDX_FUNC_MODE) &&
                       odReqIn.wdata[7:0] != MODE_USER;
    end
  end

  // NMT state and heartbeat
  always_ff @(posedge clk) begin
    if (rst) begin
      nmt_r <= NMT_BOOT;
    end else if (nmtResetCmd) begin
      nmt_r <= NMT_BOOT;
    end else begin
      unique case (nmt_r)
        NMT_BOOT: begin
          if (selfTestPass) begin
            nmt_r <= (startup_r == STARTUP_PREOP) ? NMT_PREOP : NMT_OPER;
          end
        end
        NMT_PREOP: if (nmtStartCmd) nmt_r <= NMT_OPER;
        NMT_OPER: if (nmtPreopCmd) nmt_r <= NMT_PREOP;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hb_r <= HB_BOOT;
    end else begin
      unique case (nmt_r)
        NMT_BOOT: hb_r <= HB_BOOT;
        NMT_PREOP: hb_r <= HB_PREOP;
        NMT_OPER: hb_r <= HB_OPER;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tpdo1Send_r <= 1'b0;
    end else begin
      tpdo1Send_r <= (nmt_r == NMT_OPER) && measTick && !tpdoDisabled[0] &&
                     mapCount_r[0] != 8'h00;
    end
  end

  // Start-up and manufacturer settings
  always_ff @(posedge clk) begin
    if (rst) begin
      startup_r <= STARTUP_OPER;
      nodeId_r <= NODE_ID_RST;
      bitRate_r <= BIT_RATE_RST;
      term_r <= TERM_RST;
      profile_r <= PROFILE_RST;
      mode_r <= MODE_RST;
      mavg1_r <= MAVG_RST;
      mavg2_r <= MAVG_RST;
      tau_r <= TAU_RST;
      errMask_r <= ERR_MASK_RST;
    end else if (wrEn) begin
      if (hit(odReqIn.index, IDX_STARTUP)) startup_r <= odReqIn.wdata;
      if (hit(odReqIn.index, IDX_NODE_ID)) nodeId_r <= odReqIn.wdata[7:0];
      if (hit(odReqIn.index, IDX_BIT_RATE)) bitRate_r <= odReqIn.wdata[7:0];
      if (hit(odReqIn.index, IDX_TERMINATION)) term_r <= odReqIn.wdata[7:0];
      if (hit(odReqIn.index, IDX_PROFILE)) profile_r <= odReqIn.wdata[7:0];
      if (hit(odReqIn.index, IDX_FUNC_MODE)) mode_r <= odReqIn.wdata[7:0];
      if (hit(odReqIn.index, IDX_MOVING_AVG)) begin
        if (odReqIn.sub == 8'h01) mavg1_r <= odReqIn.wdata[7:0];
        if (odReqIn.sub == 8'h02) mavg2_r <= odReqIn.wdata[7:0];
      end
      if (hit(odReqIn.index, IDX_FILTER_TAU)) tau_r <= odReqIn.wdata[15:0];
      if (hit(odReqIn.index, IDX_ERROR_MASK)) errMask_r <= odReqIn.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      kbps_r <= rateKbps(BIT_RATE_RST);
    end else begin
      kbps_r <= rateKbps(bitRate_r);
    end
  end

  // Zero adjust: written code is acted on once, then falls back to idle
  always_ff @(posedge clk) begin
    if (rst) begin
      zeroAdj_r <= ZERO_ADJ_RST;
      zeroX_r <= 1'b0;
      zeroY_r <= 1'b0;
    end else begin
      zeroX_r <= zeroAdj_r[0];
      zeroY_r <= zeroAdj_r[1];
      zeroAdj_r <= (wrEn && hit(odReqIn.index, IDX_ZERO_ADJUST)) ? odReqIn.wdata[7:0] :
                   ZERO_ADJ_RST;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      mfgErr_r <= 1'b0;
    end else begin
      mfgErr_r <= |(mfgStatus & errMask_r);
    end
  end

  assign odAck = odAck_r;
  assign odErr = odErr_r;
  assign odRdata = odRdata_r;
  assign nmtState = nmt_r;
  assign heartbeatState = hb_r;
  assign tpdo1Send = tpdo1Send_r;
  assign mfgError = mfgErr_r;
  assign cfg = '{nodeId: nodeId_r, bitRateKbps: kbps_r, termConnect: term_r[0],
                 profile: profile_r, funcMode: mode_r, movAvgLen1: mavg1_r,
                 movAvgLen2: mavg2_r, filterTau: tau_r, zeroStartX: zeroX_r,
                 zeroStartY: zeroY_r};

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_entryWrite;
    odReq && odReqIn.write && hit(odReqIn.index, IDX_TPDO1_MAP) &&
    odReqIn.sub == 8'h01 && mapCount_r[0] != 8'h00;
  endsequence
  sequence s_zeroBoth;
    wrEn && hit(odReqIn.index, IDX_ZERO_ADJUST) && odReqIn.wdata == 32'h3;
  endsequence

  a_ack_next_cycle: assert property (odReq |=> odAck)
    else $error("access not answered next cycle");
  a_entry_refused: assert property (s_entryWrite |=> odErr && $stable(mapEntry_r[0][0]))
    else $error("entry write taken while count non-zero");
  a_boot_to_oper: assert property (nmt_r == NMT_BOOT && selfTestPass && !nmtResetCmd &&
      startup_r == STARTUP_OPER |=> nmt_r == NMT_OPER)
    else $error("start-up zero did not reach operational");
  a_boot_to_preop: assert property (nmt_r == NMT_BOOT && selfTestPass && !nmtResetCmd &&
      startup_r == STARTUP_PREOP |=> nmt_r == NMT_PREOP)
    else $error("start-up four did not reach pre-operational");
  a_hb_oper: assert property (nmt_r == NMT_OPER && !nmtResetCmd && !nmtPreopCmd
      |=> heartbeatState == HB_OPER)
    else $error("heartbeat not 05 while operational");
  a_node_range: assert property (cfg.nodeId >= 8'h01 && cfg.nodeId <= NODE_ID_MAX)
    else $error("node id out of range");
  a_rate_decode: assert property (bitRate_r == 8'h03 ##1 bitRate_r == 8'h03
      |-> cfg.bitRateKbps == 16'h00FA)
    else $error("bit rate code three not 250");
  a_zero_both: assert property (s_zeroBoth |=> ##1 cfg.zeroStartX && cfg.zeroStartY
      ##1 !cfg.zeroStartX && !cfg.zeroStartY)
    else $error("zero adjust of both axes not one pulse");
  a_mask_error: assert property (|(mfgStatus & errMask_r) |=> mfgError)
    else $error("masked status bit raised no error");
  a_status_top: assert property (odReq && !odReqIn.write &&
      hit(odReqIn.index, IDX_STATUS_MAP) && odReqIn.sub == 8'h04
      |=> odRdata == {24'h000000, $past(mfgStatus[31:24])})
    else $error("fourth status byte wrong");
  a_default_map: assert property ($fell(loadDefault_r) && !$past(twoAxis) |->
      mapCount_r[0] == MAP_COUNT_ONE_AXIS)
    else $error("one-axis default count wrong");
endmodule : cotpm_config

//--- pkg/cotpm_pkg.sv
// Purpose: Constants and types of the TPDO mapping and node configuration bank
// Assumes: Object dictionary reached by index and subindex, one access per cycle
// Notes: Offsets are object indices; values are those after factory reset
package cotpm_pkg;
  // Object indices
  localparam logic [15:0] IDX_TPDO1_MAP = 16'h1A00;
  localparam logic [15:0] IDX_TPDO2_MAP = 16'h1A01;
  localparam logic [15:0] IDX_STARTUP = 16'h1F80;
  localparam logic [15:0] IDX_NODE_ID = 16'h3000;
  localparam logic [15:0] IDX_BIT_RATE = 16'h3001;
  localparam logic [15:0] IDX_TERMINATION = 16'h3003;
  localparam logic [15:0] IDX_PROFILE = 16'h3004;
  localparam logic [15:0] IDX_FUNC_MODE = 16'h3007;
  localparam logic [15:0] IDX_MOVING_AVG = 16'h300D;
  localparam logic [15:0] IDX_FILTER_TAU = 16'h300E;
  localparam logic [15:0] IDX_ZERO_ADJUST = 16'h300F;
  localparam logic [15:0] IDX_ERROR_MASK = 16'h301E;
  localparam logic [15:0] IDX_STATUS_MAP = 16'h301F;
  // Default mapping entries: index, subindex, length in bits
  localparam logic [31:0] MAP_X_AXIS = 32'h60100010;
  localparam logic [31:0] MAP_Y_AXIS = 32'h60200010;
  localparam logic [7:0] MAP_COUNT_ONE_AXIS = 8'h01;
  localparam logic [7:0] MAP_COUNT_TWO_AXIS = 8'h02;
  localparam logic [7:0] MAP_COUNT_TPDO2 = 8'h00;
  // Start-up values and heartbeat state bytes
  localparam logic [31:0] STARTUP_OPER = 32'h00000000;
  localparam logic [31:0] STARTUP_PREOP = 32'h00000004;
  localparam logic [7:0] HB_BOOT = 8'h00;
  localparam logic [7:0] HB_OPER = 8'h05;
  localparam logic [7:0] HB_PREOP = 8'h7F;
  // Reset values and limits
  localparam logic [7:0] NODE_ID_RST = 8'h01;
  localparam logic [7:0] NODE_ID_MAX = 8'h7F;
  localparam logic [7:0] BIT_RATE_RST = 8'h03;
  localparam logic [7:0] BIT_RATE_MAX = 8'h08;
  localparam logic [7:0] TERM_RST = 8'h00;
  localparam logic [7:0] TERM_MAX = 8'h01;
  localparam logic [7:0] PROFILE_RST = 8'h01;
  localparam logic [7:0] PROFILE_MAX = 8'h03;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MODE_MAX = 8'h05;
  localparam logic [7:0] MODE_USER = 8'hFF;
  localparam logic [7:0] MAVG_RST = 8'h00;
  localparam logic [7:0] MAVG_TOP_SUB = 8'h02;
  localparam logic [15:0] TAU_RST = 16'h0000;
  localparam logic [7:0] ZERO_ADJ_RST = 8'h00;
  localparam logic [7:0] ZERO_ADJ_MAX = 8'h03;
  localparam logic [31:0] ERR_MASK_RST = 32'h00000000;
  localparam logic [7:0] STATUS_TOP_SUB = 8'h04;

  typedef enum logic [1:0] {NMT_BOOT, NMT_PREOP, NMT_OPER} cotpm_nmt_type;

  typedef struct packed {
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } cotpm_req_type;

  typedef struct packed {
    logic [7:0] nodeId;
    logic [15:0] bitRateKbps;
    logic termConnect;
    logic [7:0] profile;
    logic [7:0] funcMode;
    logic [7:0] movAvgLen1;
    logic [7:0] movAvgLen2;
    logic [15:0] filterTau;
    logic zeroStartX;
    logic zeroStartY;
  } cotpm_cfg_type;
endpackage : cotpm_pkg

//--- verification/cotpm_master_model.sv
// Purpose: Configuration master issuing dictionary accesses and PDO disable bits
// Assumes: One request pulse per access, answered on the following edge
// Notes: Request fields are scrambled while idle
`timescale 1ns/1ps
module cotpm_master_model (
  // Clock
  input wire logic clk,
  // Dictionary access
  output logic odReq,
  output cotpm_pkg::cotpm_req_type odReqIn,
  input wire logic odAck,
  input wire logic odErr,
  input wire logic [31:0] odRdata,
  // PDO communication state
  output logic [1:0] tpdoDisabled
);
  import cotpm_pkg::*;

  initial begin
    odReq = 1'b0;
    odReqIn = '0;
    tpdoDisabled = 2'h0;
  end

  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sb,
      input logic [31:0] d, output logic err, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    odReq <= 1'b1;
    odReqIn <= '{write: wr, index: idx, sub: sb, wdata: d};
    @(posedge clk);
    odReq <= 1'b0;
    odReqIn <= ~{wr, idx, sb, d};
    // Answer stands for the cycle after the taking edge
    #1;
    while (odAck !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    err = (odAck === 1'b1) ? odErr : 1'bx;
    rd = odRdata;
  endtask : access

  task automatic set_disable(input int p, input logic v);
    @(posedge clk);
    tpdoDisabled[p] <= v;
  endtask : set_disable

  // Whole remap sequence; returns the number of refused steps
  task automatic remap(input int p, input logic [7:0] cnt, input logic [31:0] e0,
      input logic [31:0] e1, output int fails);
    logic err;
    logic [31:0] rd;
    logic [15:0] idx;
    idx = (p == 0) ? IDX_TPDO1_MAP : IDX_TPDO2_MAP;
    fails = 0;
    set_disable(p, 1'b1);
    access(1'b1, idx, 8'h00, 32'h00000000, err, rd);
    fails += int'(err !== 1'b0);
    access(1'b1, idx, 8'h01, e0, err, rd);
    fails += int'(err !== 1'b0);
    if (cnt > 8'h01) begin
      access(1'b1, idx, 8'h02, e1, err, rd);
      fails += int'(err !== 1'b0);
    end
    access(1'b1, idx, 8'h00, {24'h000000, cnt}, err, rd);
    fails += int'(err !== 1'b0);
    set_disable(p, 1'b0);
  endtask : remap
endmodule : cotpm_master_model

//--- verification/cotpm_config_tb.sv
// Purpose: Self-checking bench of the dictionary configuration bank
// Assumes: Master model issues all dictionary accesses
// Notes: Expected values come from the package constants and fixed tables
`timescale 1ns/1ps
module cotpm_config_tb;
  import cotpm_pkg::*;
  logic clk;
  logic rst;
  logic twoAxis, selfTestPass, nmtStartCmd, nmtPreopCmd, nmtResetCmd, measTick;
  logic [31:0] mfgStatus;
  logic odReq, odAck, odErr, tpdo1Send, mfgError;
  cotpm_req_type odReqIn;
  logic [31:0] odRdata;
  logic [1:0] tpdoDisabled;
  cotpm_nmt_type nmtState;
  logic [7:0] heartbeatState;
  cotpm_cfg_type cfg;
  int n_errors = 0;
  int check_count = 0;
  int sends, f;
  logic [15:0] kbps [9] = '{16'h03E8, 16'h0320, 16'h01F4, 16'h00FA, 16'h007D,
                            16'h0064, 16'h0032, 16'h0014, 16'h000A};

  cotpm_config DUT (.clk(clk), .rst(rst), .odReq(odReq), .odReqIn(odReqIn), .odAck(odAck),
    .odErr(odErr), .odRdata(odRdata), .twoAxis(twoAxis), .selfTestPass(selfTestPass),
    .nmtStartCmd(nmtStartCmd), .nmtPreopCmd(nmtPreopCmd), .nmtResetCmd(nmtResetCmd),
    .tpdoDisabled(tpdoDisabled), .measTick(measTick), .mfgStatus(mfgStatus),
    .nmtState(nmtState), .heartbeatState(heartbeatState), .tpdo1Send(tpdo1Send),
    .mfgError(mfgError), .cfg(cfg));

  cotpm_master_model master (.clk(clk), .odReq(odReq), .odReqIn(odReqIn), .odAck(odAck),
    .odErr(odErr), .odRdata(odRdata), .tpdoDisabled(tpdoDisabled));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] d,
      input logic expErr);
    logic e;
    logic [31:0] r;
    master.access(1'b1, idx, sb, d, e, r);
    chk($sformatf("refusal of write %h.%h", idx, sb), {31'h0, expErr}, {31'h0, e});
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] exp);
    logic e;
    logic [31:0] r;
    master.access(1'b0, idx, sb, 32'h0, e, r);
    chk($sformatf("refusal of read %h.%h", idx, sb), 32'h0, {31'h0, e});
    chk($sformatf("data of %h.%h", idx, sb), exp, r);
  endtask : rd

  task automatic cmd(input int k);
    @(posedge clk);
    case (k)
      0: nmtStartCmd <= 1'b1;
      1: nmtPreopCmd <= 1'b1;
      default: nmtResetCmd <= 1'b1;
    endcase
    @(posedge clk);
    {nmtStartCmd, nmtPreopCmd, nmtResetCmd} <= 3'h0;
  endtask : cmd

  task automatic wait_state(input cotpm_nmt_type s, input logic [7:0] hb);
    int n;
    n = 0;
    while (nmtState !== s && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    chk("nmt state", {30'h0, s}, {30'h0, nmtState});
    chk("heartbeat", {24'h0, hb}, {24'h0, heartbeatState});
  endtask : wait_state

  initial begin
    #(50 * 8000);
    n_errors++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    {twoAxis, selfTestPass, nmtStartCmd, nmtPreopCmd, nmtResetCmd, measTick} = 6'h00;
    mfgStatus = 32'hA1B2C3D4;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Factory values
    rd(IDX_TPDO1_MAP, 8'h00, 32'h01);
    rd(IDX_TPDO1_MAP, 8'h01, MAP_X_AXIS);
    rd(IDX_TPDO2_MAP, 8'h00, 32'h00);
    rd(IDX_NODE_ID, 8'h00, 32'h01);
    rd(IDX_BIT_RATE, 8'h00, 32'h03);
    chk("rate kbps", 32'h00FA, {16'h0, cfg.bitRateKbps});
    rd(IDX_TERMINATION, 8'h00, 32'h00);
    rd(IDX_PROFILE, 8'h00, 32'h01);
    rd(IDX_FUNC_MODE, 8'h00, 32'h00);
    for (int i = 0; i < 3; i++) rd(IDX_MOVING_AVG, 8'(i), (i == 0) ? 32'h02 : 32'h00);
    rd(IDX_FILTER_TAU, 8'h00, 32'h00);
    rd(IDX_ERROR_MASK, 8'h00, 32'h00);
    rd(IDX_STARTUP, 8'h00, 32'h00);
    for (int i = 0; i < 5; i++) rd(IDX_STATUS_MAP, 8'(i), (i == 0) ? 32'h04 :
        {24'h0, 8'(32'hA1B2C3D4 >> (8 * (i - 1)))});
    wr(IDX_STATUS_MAP, 8'h01, 32'h00, 1'b1);
    wr(16'h2000, 8'h00, 32'h00, 1'b1);
    // No remap before the start-up state is reached
    master.set_disable(0, 1'b1);
    wr(IDX_TPDO1_MAP, 8'h00, 32'h00, 1'b1);
    master.set_disable(0, 1'b0);
    // Value ranges
    wr(IDX_NODE_ID, 8'h00, 32'h00, 1'b1);
    wr(IDX_NODE_ID, 8'h00, 32'h7F, 1'b0);
    wr(IDX_NODE_ID, 8'h00, 32'h80, 1'b1);
    chk("node id", 32'h7F, {24'h0, cfg.nodeId});
    for (int i = 0; i < 9; i++) begin
      wr(IDX_BIT_RATE, 8'h00, 32'(i), 1'b0);
      // Decoded rate follows the code one cycle later
      @(posedge clk);
      #1;
      chk("rate kbps", {16'h0, kbps[i]}, {16'h0, cfg.bitRateKbps});
    end
    wr(IDX_BIT_RATE, 8'h00, 32'h09, 1'b1);
    wr(IDX_TERMINATION, 8'h00, 32'h01, 1'b0);
    chk("termination", 32'h1, {31'h0, cfg.termConnect});
    wr(IDX_TERMINATION, 8'h00, 32'h02, 1'b1);
    for (int i = 0; i < 7; i++) wr(IDX_PROFILE, 8'h00, 32'(i), i > 3);
    chk("profile", 32'h03, {24'h0, cfg.profile});
    for (int i = 0; i < 7; i++) wr(IDX_FUNC_MODE, 8'h00, 32'(i), i > 5);
    wr(IDX_FUNC_MODE, 8'h00, 32'hFF, 1'b0);
    chk("function mode", 32'hFF, {24'h0, cfg.funcMode});
    wr(IDX_MOVING_AVG, 8'h01, 32'h07, 1'b0);
    wr(IDX_MOVING_AVG, 8'h02, 32'h09, 1'b0);
    wr(IDX_MOVING_AVG, 8'h00, 32'h01, 1'b1);
    chk("average lengths", 32'h0709, {16'h0, cfg.movAvgLen1, cfg.movAvgLen2});
    wr(IDX_FILTER_TAU, 8'h00, 32'h1234, 1'b0);
    wr(IDX_FILTER_TAU, 8'h00, 32'h10000, 1'b1);
    chk("filter tau", 32'h1234, {16'h0, cfg.filterTau});
    for (int i = 1; i < 4; i++) begin
      wr(IDX_ZERO_ADJUST, 8'h00, 32'(i), 1'b0);
      @(posedge clk);
      #1;
      chk("zero start", 32'(i), {30'h0, cfg.zeroStartY, cfg.zeroStartX});
      @(posedge clk);
      #1;
      chk("zero start end", 32'h0, {30'h0, cfg.zeroStartY, cfg.zeroStartX});
    end
    wr(IDX_ZERO_ADJUST, 8'h00, 32'h04, 1'b1);
    // Error mask against status bits 8 (set) and 0 (clear)
    wr(IDX_ERROR_MASK, 8'h00, 32'h00000100, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk("mfg error", 32'h1, {31'h0, mfgError});
    wr(IDX_ERROR_MASK, 8'h00, 32'h00000001, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk("mfg error", 32'h0, {31'h0, mfgError});
    // Start-up into operational
    wr(IDX_STARTUP, 8'h00, 32'h05, 1'b1);
    selfTestPass <= 1'b1;
    wait_state(NMT_OPER, HB_OPER);
    @(posedge clk);
    measTick <= 1'b1;
    sends = 0;
    repeat (4) begin
      @(posedge clk);
      measTick <= 1'b0;
      #1;
      sends += int'(tpdo1Send === 1'b1);
    end
    chk("pdo sends", 32'h1, 32'(sends));
    // Remapping while operational and pre-operational
    master.set_disable(0, 1'b1);
    wr(IDX_TPDO1_MAP, 8'h01, 32'h64011010, 1'b1);
    rd(IDX_TPDO1_MAP, 8'h01, MAP_X_AXIS);
    master.remap(0, 8'h02, 32'h64011010, MAP_X_AXIS, f);
    chk("remap refusals", 32'h0, 32'(f));
    rd(IDX_TPDO1_MAP, 8'h00, 32'h02);
    rd(IDX_TPDO1_MAP, 8'h01, 32'h64011010);
    rd(IDX_TPDO1_MAP, 8'h02, MAP_X_AXIS);
    cmd(1);
    wait_state(NMT_PREOP, HB_PREOP);
    master.remap(1, 8'h01, 32'h64011010, 32'h0, f);
    chk("remap refusals", 32'h0, 32'(f));
    rd(IDX_TPDO2_MAP, 8'h00, 32'h01);
    rd(IDX_TPDO2_MAP, 8'h01, 32'h64011010);
    cmd(0);
    wait_state(NMT_OPER, HB_OPER);
    // Mode change reloads the two-axis defaults
    twoAxis <= 1'b1;
    wr(IDX_FUNC_MODE, 8'h00, 32'h01, 1'b0);
    @(posedge clk);
    rd(IDX_TPDO1_MAP, 8'h00, 32'h02);
    rd(IDX_TPDO1_MAP, 8'h01, MAP_X_AXIS);
    rd(IDX_TPDO1_MAP, 8'h02, MAP_Y_AXIS);
    // Start-up into pre-operational after a node reset
    wr(IDX_STARTUP, 8'h00, 32'h04, 1'b0);
    cmd(2);
    wait_state(NMT_PREOP, HB_PREOP);
    stop_test();
  end
endmodule : cotpm_config_tb
